//--- pkg/latch_pkg.sv
// constants and types for the channel configuration latch bank
// assumes four channels and a 4-bit latch address with 8-bit write data
package latch_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_LOCAL = 12;
  localparam int unsigned BANKS_PER_CH = 3;

  // bank index inside a channel, and the matching global addresses
  localparam logic [ADDR_W-1:0] BANK_RX = 4'h0;
  localparam logic [ADDR_W-1:0] BANK_TX = 4'h1;
  localparam logic [ADDR_W-1:0] BANK_DYN = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_GLB_RX = 4'hC;
  localparam logic [ADDR_W-1:0] ADDR_GLB_TX = 4'hD;
  localparam logic [ADDR_W-1:0] ADDR_GLB_DYN = 4'hE;

  // bit positions inside a write byte
  localparam int unsigned BIT_GLOBAL = 0;
  localparam int unsigned BIT_RATE = 1;
  localparam int unsigned BIT_CKSEL = 2;
  localparam int unsigned BIT_ENC = 3;
  localparam int unsigned BIT_RECENTER = 1;
  localparam int unsigned BIT_OE1 = 2;
  localparam int unsigned BIT_OE2 = 3;
  localparam int unsigned BIT_TXST = 4;
  localparam int unsigned BIT_RXST = 5;
  localparam int unsigned BIT_RXPWR = 6;
  localparam int unsigned BIT_REFRAME = 7;

  // reset values of the single-bit latches
  localparam logic RST_ENC = 1'b1;
  localparam logic RST_CKSEL = 1'b1;
  localparam logic RST_RATE = 1'b0;
  localparam logic RST_REFRAME = 1'b1;
  localparam logic RST_RXPWR = 1'b0;
  localparam logic RST_RXST = 1'b1;
  localparam logic RST_TXST = 1'b1;
  localparam logic RST_OE = 1'b0;
  localparam logic RST_RECENTER = 1'b1;
  localparam logic RST_GLOBAL = 1'b1;

  typedef enum logic [0:0] {RC_IDLE, RC_WAIT_EDGE} recenter_state_t;
endpackage

//--- pkg/bank_wr_if.sv
// write strobes and data carried from the address decoder to one channel
// assumes one clock; strobes are one-cycle pulses
`timescale 1ns/100ps
interface bank_wr_if;
  logic                           wr_tx;
  logic                           wr_dyn;
  logic [latch_pkg::DATA_W-1:0]   data;
  modport src (output wr_tx, output wr_dyn, output data);
  modport dst (input wr_tx, input wr_dyn, input data);
endinterface

//--- hw/phase_recenter.sv
// self-clearing phase buffer recenter latch of one channel
// assumes tx_clk_in is a foreign clock seen as a plain level
`timescale 1ns/100ps
module phase_recenter (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic wr_in,
  input  wire logic wr_bit_in,
  input  wire logic tx_clk_in,
  output logic      recenter_n_out,
  output logic      pulse_out
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d, pulse_q, latch_q, latch_d;
  latch_pkg::recenter_state_t state_q, state_d;
  wire  tx_rise = lvl_d & ~lvl_q;
  wire  wr_zero = wr_in & ~wr_bit_in;
  wire  wr_one = wr_in & wr_bit_in;
  wire  done = (state_q == latch_pkg::RC_WAIT_EDGE) & tx_rise;

  // the level moves only once the two later stages agree
  assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;

  always_comb begin
    state_d = state_q;
    latch_d = latch_q;
    unique case (state_q)
      latch_pkg::RC_IDLE: begin
        if (wr_zero) begin
          state_d = latch_pkg::RC_WAIT_EDGE;
          latch_d = 1'b0;
        end
      end
      latch_pkg::RC_WAIT_EDGE: begin
        // a fresh zero write in the finishing cycle keeps the request
        if (wr_one || (done && !wr_zero)) begin
          state_d = latch_pkg::RC_IDLE;
          latch_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      lvl_q   <= 1'b0;
      pulse_q <= 1'b0;
      latch_q <= latch_pkg::RST_RECENTER;
      state_q <= latch_pkg::RC_IDLE;
    end else begin
      s1_q    <= tx_clk_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      lvl_q   <= lvl_d;
      pulse_q <= done;
      latch_q <= latch_d;
      state_q <= state_d;
    end
  end

  assign recenter_n_out = latch_q;
  assign pulse_out = pulse_q;

  AST_RECENTER_ONLY_ON_EDGE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    pulse_q |-> $past(tx_rise) && $past(state_q == latch_pkg::RC_WAIT_EDGE))
    else $error("recenter pulse without a tx clock edge");
  AST_RECENTER_SELF_CLEAR: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (done && !wr_in) |=> latch_q)
    else $error("recenter latch did not clear itself");
endmodule // phase_recenter

//--- hw/channel_bank.sv
// transmit static and dynamic latches of one channel
// assumes strobes arrive already decoded for this channel
`timescale 1ns/100ps
module channel_bank (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  bank_wr_if.dst    wr,
  output logic      enc_on_out,
  output logic      cksel_out,
  output logic      rate_out,
  output logic      reframe_out,
  output logic      rxpwr_out,
  output logic      rxst_n_out,
  output logic      txst_n_out,
  output logic      oe1_out,
  output logic      oe2_out
);
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      enc_on_out  <= latch_pkg::RST_ENC;
      cksel_out   <= latch_pkg::RST_CKSEL;
      rate_out    <= latch_pkg::RST_RATE;
      reframe_out <= latch_pkg::RST_REFRAME;
      rxpwr_out   <= latch_pkg::RST_RXPWR;
      rxst_n_out  <= latch_pkg::RST_RXST;
      txst_n_out  <= latch_pkg::RST_TXST;
      oe1_out     <= latch_pkg::RST_OE;
      oe2_out     <= latch_pkg::RST_OE;
    end else begin
      if (wr.wr_tx) begin
        enc_on_out <= wr.data[latch_pkg::BIT_ENC];
        cksel_out  <= wr.data[latch_pkg::BIT_CKSEL];
        rate_out   <= wr.data[latch_pkg::BIT_RATE];
      end
      if (wr.wr_dyn) begin
        reframe_out <= wr.data[latch_pkg::BIT_REFRAME];
        rxpwr_out   <= wr.data[latch_pkg::BIT_RXPWR];
        rxst_n_out  <= wr.data[latch_pkg::BIT_RXST];
        txst_n_out  <= wr.data[latch_pkg::BIT_TXST];
        oe1_out     <= wr.data[latch_pkg::BIT_OE1];
        oe2_out     <= wr.data[latch_pkg::BIT_OE2];
      end
    end
  end
endmodule // channel_bank

//--- hw/serdes_channel_config_latches.sv
// top of the four-channel configuration latch bank
// assumes the host writes one byte per strobe; pins are asynchronous
`timescale 1ns/100ps
module serdes_channel_config_latches (
  input  wire logic                              clk_in,
  input  wire logic                              rstn_in,
  input  wire logic                              cfg_write_in,
  input  wire logic [latch_pkg::ADDR_W-1:0]      cfg_addr_in,
  input  wire logic [latch_pkg::DATA_W-1:0]      cfg_data_in,
  input  wire logic [latch_pkg::NUM_CH-1:0]      speed_range_select_in,
  input  wire logic [latch_pkg::NUM_CH-1:0]      tx_input_clock_in,
  output logic [latch_pkg::NUM_CH-1:0]           tx_encoder_on_out,
  output logic [latch_pkg::NUM_CH-1:0]           tx_input_clock_select_out,
  output logic [latch_pkg::NUM_CH-1:0]           tx_pll_rate_select_out,
  output logic [latch_pkg::NUM_CH-1:0]           tx_phase_buffer_bypass_out,
  output logic [latch_pkg::NUM_CH-1:0]           tx_dual_edge_capture_out,
  output logic [latch_pkg::NUM_CH-1:0]           rate_config_invalid_out,
  output logic [latch_pkg::NUM_CH-1:0]           reframe_allow_out,
  output logic [latch_pkg::NUM_CH-1:0]           rx_channel_power_on_out,
  output logic [latch_pkg::NUM_CH-1:0]           rx_selftest_off_n_out,
  output logic [latch_pkg::NUM_CH-1:0]           tx_selftest_off_n_out,
  output logic [latch_pkg::NUM_CH-1:0]           primary_driver_on_out,
  output logic [latch_pkg::NUM_CH-1:0]           secondary_driver_on_out,
  output logic [latch_pkg::NUM_CH-1:0]           primary_driver_pd_out,
  output logic [latch_pkg::NUM_CH-1:0]           secondary_driver_pd_out,
  output logic [latch_pkg::NUM_CH-1:0]           channel_logic_pd_out,
  output logic [latch_pkg::NUM_CH-1:0]           phase_buffer_recenter_n_out,
  output logic [latch_pkg::NUM_CH-1:0]           phase_recenter_pulse_out,
  output logic [latch_pkg::NUM_LOCAL-1:0]        global_write_participate_out
);
  localparam int unsigned NC = latch_pkg::NUM_CH;

  // address of bank k of channel c
  function automatic logic [latch_pkg::ADDR_W-1:0] bank_addr(
    input int unsigned ch, input logic [latch_pkg::ADDR_W-1:0] k);
    logic [latch_pkg::ADDR_W-1:0] base;
    base = latch_pkg::ADDR_W'(ch * latch_pkg::BANKS_PER_CH);
    return base + k;
  endfunction

  logic [latch_pkg::NUM_LOCAL-1:0] participate_q;
  logic [NC-1:0] spd_s1_q, spd_s2_q, spd_s3_q, spd_lvl_q, spd_lvl_d;
  logic [NC-1:0] bypass_q, dual_q, invalid_q, logic_pd_q;
  logic [NC-1:0] pd1_q, pd2_q, wr_tx_w, wr_dyn_w;
  logic [NC-1:0] enc_w, cksel_w, rate_w, oe1_w, oe2_w;

  wire local_wr = cfg_write_in &&
                  (cfg_addr_in < latch_pkg::ADDR_W'(latch_pkg::NUM_LOCAL));
  wire force_glb = cfg_data_in[latch_pkg::BIT_GLOBAL];
  wire glb_tx = cfg_write_in && (cfg_addr_in == latch_pkg::ADDR_GLB_TX);
  wire glb_dyn = cfg_write_in && (cfg_addr_in == latch_pkg::ADDR_GLB_DYN);

  // speed select is a pin: three stages, level moves once two agree
  assign spd_lvl_d = (spd_s2_q & spd_s3_q) |
                     (spd_lvl_q & (spd_s2_q ^ spd_s3_q));

  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_ch
      localparam logic [latch_pkg::ADDR_W-1:0] A_TX =
        bank_addr(c, latch_pkg::BANK_TX);
      localparam logic [latch_pkg::ADDR_W-1:0] A_DYN =
        bank_addr(c, latch_pkg::BANK_DYN);
      bank_wr_if wr_bus ();
      wire tx_join = participate_q[A_TX] | force_glb;
      wire dyn_join = participate_q[A_DYN] | force_glb;
      assign wr_tx_w[c] = (cfg_write_in && cfg_addr_in == A_TX) ||
                          (glb_tx && tx_join);
      assign wr_dyn_w[c] = (cfg_write_in && cfg_addr_in == A_DYN) ||
                           (glb_dyn && dyn_join);
      assign wr_bus.wr_tx = wr_tx_w[c];
      assign wr_bus.wr_dyn = wr_dyn_w[c];
      assign wr_bus.data = cfg_data_in;

      channel_bank u_bank (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .wr          (wr_bus.dst),
        .enc_on_out  (enc_w[c]),
        .cksel_out   (cksel_w[c]),
        .rate_out    (rate_w[c]),
        .reframe_out (reframe_allow_out[c]),
        .rxpwr_out   (rx_channel_power_on_out[c]),
        .rxst_n_out  (rx_selftest_off_n_out[c]),
        .txst_n_out  (tx_selftest_off_n_out[c]),
        .oe1_out     (oe1_w[c]),
        .oe2_out     (oe2_w[c])
      );

      phase_recenter u_recenter (
        .clk_in         (clk_in),
        .rstn_in        (rstn_in),
        .wr_in          (wr_dyn_w[c]),
        .wr_bit_in      (cfg_data_in[latch_pkg::BIT_RECENTER]),
        .tx_clk_in      (tx_input_clock_in[c]),
        .recenter_n_out (phase_buffer_recenter_n_out[c]),
        .pulse_out      (phase_recenter_pulse_out[c])
      );
    end
  endgenerate

  // participate bits change only on a direct write to their own address
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      participate_q <= {latch_pkg::NUM_LOCAL{latch_pkg::RST_GLOBAL}};
    end else if (local_wr) begin
      participate_q[cfg_addr_in] <= cfg_data_in[latch_pkg::BIT_GLOBAL];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      spd_s1_q <= '0;
      spd_s2_q <= '0;
      spd_s3_q <= '0;
      spd_lvl_q <= '0;
    end else begin
      spd_s1_q <= speed_range_select_in;
      spd_s2_q <= spd_s1_q;
      spd_s3_q <= spd_s2_q;
      spd_lvl_q <= spd_lvl_d;
    end
  end

  // derived controls are registered so every data output except the two driver enables leaves a flop
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bypass_q   <= {NC{latch_pkg::RST_CKSEL}};
      dual_q     <= {NC{latch_pkg::RST_CKSEL & latch_pkg::RST_RATE}};
      invalid_q  <= '0;
      pd1_q      <= {NC{~latch_pkg::RST_OE}};
      pd2_q      <= {NC{~latch_pkg::RST_OE}};
      logic_pd_q <= {NC{~latch_pkg::RST_OE}};
    end else begin
      bypass_q   <= cksel_w;
      dual_q     <= cksel_w & rate_w;
      invalid_q  <= rate_w & ~spd_lvl_q;
      pd1_q      <= ~oe1_w;
      pd2_q      <= ~oe2_w;
      logic_pd_q <= ~oe1_w & ~oe2_w;
    end
  end

  // driver enables are also gated by reset itself so no glitch leaks out
  assign primary_driver_on_out = oe1_w & {NC{rstn_in}};
  assign secondary_driver_on_out = oe2_w & {NC{rstn_in}};
  assign tx_encoder_on_out = enc_w;
  assign tx_input_clock_select_out = cksel_w;
  assign tx_pll_rate_select_out = rate_w;
  assign tx_phase_buffer_bypass_out = bypass_q;
  assign tx_dual_edge_capture_out = dual_q;
  assign rate_config_invalid_out = invalid_q;
  assign primary_driver_pd_out = pd1_q;
  assign secondary_driver_pd_out = pd2_q;
  assign channel_logic_pd_out = logic_pd_q;
  assign global_write_participate_out = participate_q;

  AST_RESET_VALUES: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> tx_encoder_on_out == {NC{1'b1}} &&
      tx_pll_rate_select_out == '0 && reframe_allow_out == {NC{1'b1}} &&
      rx_selftest_off_n_out == {NC{1'b1}} &&
      tx_selftest_off_n_out == {NC{1'b1}} &&
      rx_channel_power_on_out == '0 &&
      phase_buffer_recenter_n_out == {NC{1'b1}})
    else $error("latches not at reset values after release");
  AST_BYPASS_FOLLOWS_SELECT: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    rstn_in |=> tx_phase_buffer_bypass_out ==
      $past(tx_input_clock_select_out))
    else $error("buffer bypass does not follow clock select");
  AST_DUAL_EDGE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (rstn_in && tx_input_clock_select_out[0] && tx_pll_rate_select_out[0])
      |=> tx_dual_edge_capture_out[0])
    else $error("dual edge capture missing");
  AST_RATE_INVALID: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (rstn_in && tx_pll_rate_select_out[2] && !spd_lvl_q[2])
      |=> rate_config_invalid_out[2])
    else $error("invalid rate combination not flagged");
  AST_DIRECT_DYN_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (cfg_write_in && cfg_addr_in == bank_addr(2, latch_pkg::BANK_DYN))
      |=> primary_driver_on_out[2] == $past(cfg_data_in[latch_pkg::BIT_OE1])
      ##1 primary_driver_pd_out[2] == !primary_driver_on_out[2])
    else $error("direct driver write not applied");
  AST_LOGIC_POWER_DOWN: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (!primary_driver_on_out[3] && !secondary_driver_on_out[3])[*2]
      |-> channel_logic_pd_out[3])
    else $error("channel logic not powered down");
  AST_RESET_DRIVERS_OFF: assert property (
    @(posedge clk_in)
    !rstn_in |-> primary_driver_on_out == '0 &&
      secondary_driver_on_out == '0)
    else $error("driver enabled during reset");
  AST_EXCLUDED_HOLDS: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (glb_tx && !force_glb && !participate_q[bank_addr(1, latch_pkg::BANK_TX)])
      |=> $stable(tx_pll_rate_select_out[1]))
    else $error("excluded channel changed on global write");
  AST_FORCED_GLOBAL: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (glb_tx && force_glb) |=> tx_pll_rate_select_out ==
      {NC{$past(cfg_data_in[latch_pkg::BIT_RATE])}})
    else $error("forced global write missed a channel");
  AST_GLOBAL_PARTICIPATE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (glb_dyn && participate_q[bank_addr(0, latch_pkg::BANK_DYN)]) |=>
      reframe_allow_out[0] == $past(cfg_data_in[latch_pkg::BIT_REFRAME]))
    else $error("participating channel missed a global write");
  AST_RECENTER_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_dyn_w[0] && !cfg_data_in[latch_pkg::BIT_RECENTER])
      |=> !phase_buffer_recenter_n_out[0])
    else $error("recenter write of zero not taken");
  AST_ENC_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_tx_w[0] |=> tx_encoder_on_out[0] ==
      $past(cfg_data_in[latch_pkg::BIT_ENC]))
    else $error("encoder latch write not applied");
  AST_SELECT_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_tx_w[1] |=> tx_input_clock_select_out[1] ==
      $past(cfg_data_in[latch_pkg::BIT_CKSEL]))
    else $error("clock select latch write not applied");
  AST_RATE_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_tx_w[3] |=> tx_pll_rate_select_out[3] ==
      $past(cfg_data_in[latch_pkg::BIT_RATE]))
    else $error("rate latch write not applied");
  // a frozen framer must not see its enable move without a write
  AST_REFRAME_HOLDS: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (rstn_in && !wr_dyn_w[2]) |=> $stable(reframe_allow_out[2]))
    else $error("reframe latch changed without a write");
  AST_RX_POWER_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_dyn_w[1] |=> rx_channel_power_on_out[1] ==
      $past(cfg_data_in[latch_pkg::BIT_RXPWR]))
    else $error("receive power latch write not applied");
  AST_RX_SELFTEST_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_dyn_w[3] |=> rx_selftest_off_n_out[3] ==
      $past(cfg_data_in[latch_pkg::BIT_RXST]))
    else $error("receive self-test latch write not applied");
  AST_TX_SELFTEST_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_dyn_w[0] |=> tx_selftest_off_n_out[0] ==
      $past(cfg_data_in[latch_pkg::BIT_TXST]))
    else $error("transmit self-test latch write not applied");
  AST_SECONDARY_WRITE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    wr_dyn_w[1] |=> secondary_driver_on_out[1] ==
      $past(cfg_data_in[latch_pkg::BIT_OE2])
      ##1 secondary_driver_pd_out[1] == !secondary_driver_on_out[1])
    else $error("secondary driver write not applied");
  AST_GLOBAL_RECENTER: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (glb_dyn && force_glb && !cfg_data_in[latch_pkg::BIT_RECENTER])
      |=> phase_buffer_recenter_n_out == '0)
    else $error("forced global recenter missed a channel");
  AST_LOCAL_PARTICIPATE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (cfg_write_in && cfg_addr_in == bank_addr(1, latch_pkg::BANK_TX))
      |=> global_write_participate_out[bank_addr(1, latch_pkg::BANK_TX)] ==
      $past(cfg_data_in[latch_pkg::BIT_GLOBAL]))
    else $error("participate bit write not applied");
  AST_FORCED_DYN_GLOBAL: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (glb_dyn && force_glb) |=> rx_channel_power_on_out ==
      {NC{$past(cfg_data_in[latch_pkg::BIT_RXPWR])}})
    else $error("forced global dynamic write missed a channel");
  // global addresses carry data only, never participate bits
  AST_GLOBAL_KEEPS_PARTICIPATE: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    (rstn_in && (glb_tx || glb_dyn)) |=> $stable(participate_q))
    else $error("global write changed participate bits");

  COV_FORCED_GLOBAL: cover property (
    @(posedge clk_in) disable iff (!rstn_in) glb_dyn && force_glb);
  COV_RECENTER_DONE: cover property (
    @(posedge clk_in) disable iff (!rstn_in) phase_recenter_pulse_out[0]);
  COV_EXCLUDED: cover property (
    @(posedge clk_in) disable iff (!rstn_in)
    glb_tx && !force_glb && participate_q != {latch_pkg::NUM_LOCAL{1'b1}});
  COV_DUAL_EDGE: cover property (
    @(posedge clk_in) disable iff (!rstn_in) |tx_dual_edge_capture_out);
  COV_RATE_INVALID: cover property (
    @(posedge clk_in) disable iff (!rstn_in) |rate_config_invalid_out);
endmodule // serdes_channel_config_latches

//--- test/cfg_host_model.sv
// host model driving the latch write port and the speed select pins
// assumes one clock; the bench calls its tasks from a single process
`timescale 1ns/100ps
module cfg_host_model (
  input  wire logic                     clk_in,
  output logic                          cfg_write_out,
  output logic [latch_pkg::ADDR_W-1:0]  cfg_addr_out,
  output logic [latch_pkg::DATA_W-1:0]  cfg_data_out,
  output logic [latch_pkg::NUM_CH-1:0]  speed_range_select_out
);
  initial begin
    cfg_write_out = 1'b0;
    cfg_addr_out = 4'hF;
    cfg_data_out = 8'hFF;
    speed_range_select_out = 4'hF;
  end
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cfg_write_out <= 1'b1;
    cfg_addr_out <= a;
    cfg_data_out <= d;
  endtask
  // released address and data are scrambled so no hold is relied upon
  task automatic idle();
    @(posedge clk_in);
    cfg_write_out <= 1'b0;
    cfg_addr_out <= ~cfg_addr_out;
    cfg_data_out <= ~cfg_data_out;
  endtask
  // a low speed pin with rate 1 is only set by the invalid-case test
  task automatic set_speed(input logic [3:0] s);
    @(posedge clk_in);
    speed_range_select_out <= s;
  endtask
endmodule // cfg_host_model

//--- test/serdes_channel_config_latches_test.sv
// self-checking bench for the four-channel configuration latch bank
// assumes the host model drives the write port; tx clocks are slow levels
`timescale 1ns/100ps
module serdes_channel_config_latches_test;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        wr_s;
  logic [3:0]  addr;
  logic [7:0]  data;
  logic [3:0]  spd;
  logic [3:0]  tx_clk = 4'h0;
  logic [3:0]  enc, sel, rate, byp, dual, inv, rf, pwr, rxs, txs;
  logic [3:0]  oe1, oe2, pd1, pd2, lpd, rcn, pls;
  logic [11:0] part;
  logic [3:0]  e_enc, e_sel, e_rate, e_rf, e_pwr, e_rxs, e_txs;
  logic [3:0]  e_oe1, e_oe2, e_rc;
  logic [11:0] e_part;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #2 clk_in = ~clk_in;

  cfg_host_model i_cfg_host_model (.clk_in(clk_in), .cfg_write_out(wr_s),
    .cfg_addr_out(addr), .cfg_data_out(data),
    .speed_range_select_out(spd));

  serdes_channel_config_latches i_serdes_channel_config_latches (
    .clk_in(clk_in), .rstn_in(rstn_in), .cfg_write_in(wr_s),
    .cfg_addr_in(addr), .cfg_data_in(data),
    .speed_range_select_in(spd), .tx_input_clock_in(tx_clk),
    .tx_encoder_on_out(enc), .tx_input_clock_select_out(sel),
    .tx_pll_rate_select_out(rate), .tx_phase_buffer_bypass_out(byp),
    .tx_dual_edge_capture_out(dual), .rate_config_invalid_out(inv),
    .reframe_allow_out(rf), .rx_channel_power_on_out(pwr),
    .rx_selftest_off_n_out(rxs), .tx_selftest_off_n_out(txs),
    .primary_driver_on_out(oe1), .secondary_driver_on_out(oe2),
    .primary_driver_pd_out(pd1), .secondary_driver_pd_out(pd2),
    .channel_logic_pd_out(lpd), .phase_buffer_recenter_n_out(rcn),
    .phase_recenter_pulse_out(pls), .global_write_participate_out(part));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic cmp_ch(string n, logic [3:0] e, logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_part(logic [11:0] e, logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL participate expected %h seen %h", e, g);
    end
  endtask

  task automatic model_rst();
    {e_enc, e_sel, e_rate, e_rf} = 16'hFF0F;
    {e_pwr, e_rxs, e_txs, e_oe1, e_oe2, e_rc} = 24'h0FF00F;
    e_part = 12'hFFF;
  endtask
  task automatic set_bank(int c, int k, logic [7:0] d);
    if (k == 1) begin
      {e_enc[c], e_sel[c], e_rate[c]} = d[3:1];
    end
    if (k == 2) begin
      {e_rf[c], e_pwr[c], e_rxs[c], e_txs[c], e_oe2[c], e_oe1[c],
       e_rc[c]} = d[7:1];
    end
  endtask
  // the global addresses never touch participate bits; 12 and 15 do nothing
  task automatic apply(logic [3:0] a, logic [7:0] d);
    if (a < 4'hC) begin
      e_part[a] = d[0];
      set_bank(a / 3, a % 3, d);
    end else if (a == 4'hD || a == 4'hE) begin
      for (int c = 0; c < 4; c++) begin
        if (d[0] || e_part[3 * c + a - 12]) begin
          set_bank(c, a - 12, d);
        end
      end
    end
  endtask

  task automatic check_all();
    cmp_ch("encoder", e_enc, enc);
    cmp_ch("clock_select", e_sel, sel);
    cmp_ch("buffer_bypass", e_sel, byp);
    cmp_ch("rate", e_rate, rate);
    cmp_ch("dual_edge", e_sel & e_rate, dual);
    cmp_ch("invalid", e_rate & ~spd, inv);
    cmp_ch("reframe", e_rf, rf);
    cmp_ch("rx_power", e_pwr, pwr);
    cmp_ch("rx_selftest_n", e_rxs, rxs);
    cmp_ch("tx_selftest_n", e_txs, txs);
    cmp_ch("primary_on", e_oe1, oe1);
    cmp_ch("secondary_on", e_oe2, oe2);
    cmp_ch("primary_pd", ~e_oe1, pd1);
    cmp_ch("secondary_pd", ~e_oe2, pd2);
    cmp_ch("logic_pd", ~(e_oe1 | e_oe2), lpd);
    cmp_ch("recenter_n", e_rc, rcn);
    cmp_ch("recenter_pulse", 4'h0, pls);
    cmp_part(e_part, part);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
    check_all();
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    i_cfg_host_model.put(a, d);
    apply(a, d);
    i_cfg_host_model.idle();
    settle();
  endtask

  task automatic t_reset_values();
    model_rst();
    settle();
    $display("test reset_values done");
  endtask
  task automatic t_per_channel();
    for (int c = 0; c < 4; c++) begin
      wr(4'(3 * c + 1), 8'h03);
      wr(4'(3 * c + 1), 8'h07);
      wr(4'(3 * c + 1), c[0] ? 8'h0E : 8'h0F);
      wr(4'(3 * c), 8'h00);
      wr(4'(3 * c + 2), 8'h4B);
      wr(4'(3 * c + 2), 8'h07);
      wr(4'(3 * c + 2), c[1] ? 8'h02 : 8'h03);
    end
    $display("test per_channel done");
  endtask
  task automatic t_global();
    i_cfg_host_model.put(4'h0, 8'h01);
    apply(4'h0, 8'h01);
    i_cfg_host_model.put(4'hC, 8'h00);
    i_cfg_host_model.idle();
    settle();
    wr(4'hF, 8'h00);
    wr(4'hD, 8'h08);
    wr(4'hD, 8'h05);
    wr(4'hE, 8'hC6);
    wr(4'hE, 8'h4B);
    $display("test global done");
  endtask
  task automatic t_recenter();
    int n;
    wr(4'hE, 8'hC5);
    repeat (10) @(posedge clk_in);
    #1;
    check_all();
    wr(4'h5, 8'hC7);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_in);
      tx_clk[c] <= 1'b1;
      n = 0;
      while (n < 12 && pls[c] !== 1'b1) begin
        @(posedge clk_in);
        #1;
        n++;
      end
      e_rc[c] = 1'b1;
      cmp_ch("recenter_pulse", c == 1 ? 4'h0 : 4'(1 << c), pls);
      cmp_ch("recenter_n", e_rc, rcn);
      @(posedge clk_in);
      tx_clk[c] <= 1'b0;
      #1;
      check_all();
    end
    $display("test recenter done");
  endtask
  task automatic t_invalid();
    wr(4'h7, 8'h0F);
    i_cfg_host_model.set_speed(4'hB);
    repeat (8) @(posedge clk_in);
    settle();
    i_cfg_host_model.set_speed(4'hF);
    repeat (8) @(posedge clk_in);
    settle();
    $display("test invalid done");
  endtask
  task automatic t_reset_drivers();
    wr(4'hE, 8'h0F);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    #1;
    cmp_ch("primary_on", 4'h0, oe1);
    cmp_ch("secondary_on", 4'h0, oe2);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    model_rst();
    #1;
    check_all();
    $display("test reset_drivers done");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset_values();
    t_per_channel();
    t_global();
    t_recenter();
    t_invalid();
    t_reset_drivers();
    end_of_test();
  end
endmodule // serdes_channel_config_latches_test
